// *** verilog/port_gpio.v ***
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "port_gpio_regs.vh"
// Summary of operation
// R1 - direction one tristates the pin driver
// R2 - direction zero drives the output latch
// R3 - analog-capable pins start analog after reset
// R4 - data read returns sampled pin levels
// R5 - data write stores read-modified pin value
// R6 - direction still governs analog pins
// R7 - analog pins read back as zero
// R8 - software clears analog select for digital
// R9 - crystal modes read direction 7:6 as one
// R10 - direction, analog select reset to ones
// R11 - pin three is input only
// R12 - pin four: comparator one out, timer0 clock
// R13 - pin five: comparator two out, slave select
// R14 - pins six, seven serve oscillator
// R15 - pin three display needs both enables
// R16 - second port pull-ups, upper change detect
// R17 - analog select kills digital input path; only data reads are masked, slave select still follows pin five
// R18 - analog select leaves digital output alone
// R19 - enabled alternate function overrides port
module port_gpio (
    input  wire        CLK_SYS_I,     // 20 MHz system clock
    input  wire        RESET_I,       // synchronous reset, active high
    input  wire [7:0]  AWADDR_I,      // write address
    input  wire        AWVALID_I,     // write address valid
    output reg         AWREADY_O,     // write address ready
    input  wire [31:0] WDATA_I,       // write data
    input  wire [3:0]  WSTRB_I,       // write byte strobes
    input  wire        WVALID_I,      // write data valid
    output reg         WREADY_O,      // write data ready
    output reg  [1:0]  BRESP_O,       // write response
    output reg         BVALID_O,      // write response valid
    input  wire        BREADY_I,      // write response ready
    input  wire [7:0]  ARADDR_I,      // read address
    input  wire        ARVALID_I,     // read address valid
    output reg         ARREADY_O,     // read address ready
    output reg  [31:0] RDATA_O,       // read data
    output reg  [1:0]  RRESP_O,       // read response
    output reg         RVALID_O,      // read data valid
    input  wire        RREADY_I,      // read data ready
    input  wire [7:0]  PA_IN_I,       // first port pin levels
    output reg  [7:0]  PA_OUT_O,      // first port pin drive value
    output reg  [7:0]  PA_OE_O,       // first port pin drive enable
    input  wire [7:0]  PB_IN_I,       // second port pin levels
    output reg  [7:0]  PB_OUT_O,      // second port pin drive value
    output reg  [7:0]  PB_OE_O,       // second port pin drive enable
    output reg  [7:0]  PB_PULLUP_O,   // second port weak pull-up on
    input  wire        COMP1_OUT_I,   // comparator one result
    input  wire        COMP2_OUT_I,   // comparator two result
    output reg         TIMER0_CLK_O,  // pin four as timer0 clock
    output reg         SLAVE_SEL_O,   // pin five as slave select
    output reg         DISP_PIN3_O,   // pin three display drive on
    output reg         OSC_PINS_O,    // pins six, seven owned by osc
    output reg         CHANGE_FLAG_O  // second port change flag
);

    // register file
    reg  [7:0] first_latch;     // first port output latch, no reset
    reg  [7:0] first_dir;       // first port direction
    reg  [7:0] analog_sel;      // analog select bits
    reg  [7:0] comp_ctrl;       // comparator control, storage only
    reg  [8:0] alt_ctrl;        // alternate function enables
    reg  [7:0] second_latch;    // second port output latch, no reset
    reg  [7:0] second_dir;      // second port direction
    reg  [7:0] second_pullup;   // second port pull-up enables
    reg  [3:0] chg_en;          // change detect enables, pins 7:4
    reg  [3:0] last_read;       // upper second port at last access
    reg        change_flag;     // sticky change flag

    // bus holding state
    reg        aw_held;         // write address captured
    reg        w_held;          // write data captured
    reg  [7:0] wr_addr;         // captured write address
    reg  [31:0] wr_data;        // captured write data
    reg  [3:0] wr_strb;         // captured strobes

    // synchronised pins
    wire [15:0] pins_sync;      // {second, first}
    wire [7:0]  pa_sync = pins_sync[7:0];
    wire [7:0]  pb_sync = pins_sync[15:8];

    pin_sync #(
        .WIDTH (16)
    ) u_sync (
        .clk_i   (CLK_SYS_I),
        .async_i ({PB_IN_I, PA_IN_I}),
        .sync_o  (pins_sync)
    );

    // decoded control
    wire [1:0] osc_mode = alt_ctrl[`ALT_OSC_HI:`ALT_OSC_LO];
    wire       xtal_mode = (osc_mode == `OSC_CRYSTAL) ||
                           (osc_mode == `OSC_HIGH_SPEED) ||
                           (osc_mode == `OSC_LOW_POWER);
    wire       osc_owns = xtal_mode | alt_ctrl[`ALT_T1_OSC_EN];
    wire       c1_out_en = alt_ctrl[`ALT_C1_OUT_EN];
    wire       c2_out_en = alt_ctrl[`ALT_C2_OUT_EN];
    wire       disp_pin3 = alt_ctrl[`ALT_DISP_EN] &
                           alt_ctrl[`ALT_SEG15_EN]; // [R15]

    // analog channels sit on pins 5 and 3:0
    wire [7:0] pa_analog = {2'b00, analog_sel[4], 1'b0,
                            analog_sel[3:0]};

    // digital read path, analog pins forced low [R4] [R7] [R17]
    wire [7:0] pa_read = pa_sync & ~pa_analog;
    wire [7:0] pb_read = pb_sync;

    // direction readback, crystal modes pin 7:6 high [R9]
    wire [7:0] dir_read = xtal_mode ? (first_dir | 8'hc0) : first_dir;

    // mismatch on enabled upper pins of the second port [R16]
    wire       mismatch = |((pb_sync[7:4] ^ last_read) & chg_en);

    // handshake events
    wire       aw_take = AWVALID_I & AWREADY_O;
    wire       w_take  = WVALID_I & WREADY_O;
    wire       ar_take = ARVALID_I & ARREADY_O;
    wire       wr_go   = aw_held & w_held & ~BVALID_O;
    wire       wr_lane0 = wr_strb[0];

    // address hit checks
    function hit;
        input [7:0] a;
        begin
            hit = (a == `OFS_FIRST_DATA)   || (a == `OFS_FIRST_DIR)  ||
                  (a == `OFS_ANALOG_SEL)   || (a == `OFS_COMP_CTRL)  ||
                  (a == `OFS_ALT_CTRL)     || (a == `OFS_SECOND_DATA) ||
                  (a == `OFS_SECOND_DIR)   || (a == `OFS_SECOND_PULLUP) ||
                  (a == `OFS_SECOND_CHG_EN) || (a == `OFS_STATUS);
        end
    endfunction

    // read data mux
    reg [31:0] rd_mux;          // combinational read value
    always @* begin
        rd_mux = 32'h0000_0000;
        case (ARADDR_I)
            `OFS_FIRST_DATA:    rd_mux[7:0] = pa_read;   // [R4] [R7]
            `OFS_FIRST_DIR:     rd_mux[7:0] = dir_read;  // [R9]
            `OFS_ANALOG_SEL:    rd_mux[7:0] = analog_sel;
            `OFS_COMP_CTRL:     rd_mux[7:0] = comp_ctrl;
            `OFS_ALT_CTRL:      rd_mux[8:0] = alt_ctrl;
            `OFS_SECOND_DATA:   rd_mux[7:0] = pb_read;
            `OFS_SECOND_DIR:    rd_mux[7:0] = second_dir;
            `OFS_SECOND_PULLUP: rd_mux[7:0] = second_pullup;
            `OFS_SECOND_CHG_EN: rd_mux[7:4] = chg_en;
            `OFS_STATUS:        rd_mux[`STAT_CHANGE] = change_flag;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // axi write channel: one write in flight, either order
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            AWREADY_O <= 1'b1;
            WREADY_O  <= 1'b1;
            BVALID_O  <= 1'b0;
            BRESP_O   <= `RESP_OKAY;
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 32'h0000_0000;
            wr_strb   <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held   <= 1'b1;
                AWREADY_O <= 1'b0;
                wr_addr   <= AWADDR_I;
            end
            if (w_take) begin
                w_held   <= 1'b1;
                WREADY_O <= 1'b0;
                wr_data  <= WDATA_I;
                wr_strb  <= WSTRB_I;
            end
            if (wr_go) begin
                // unmapped addresses get slave error, no effect
                BVALID_O <= 1'b1;
                BRESP_O  <= hit(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
            end
            if (BVALID_O & BREADY_I) begin
                // reopen only after response is taken
                BVALID_O  <= 1'b0;
                AWREADY_O <= 1'b1;
                WREADY_O  <= 1'b1;
            end
        end
    end

    // axi read channel, answer one cycle after address
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            ARREADY_O <= 1'b1;
            RVALID_O  <= 1'b0;
            RDATA_O   <= 32'h0000_0000;
            RRESP_O   <= `RESP_OKAY;
        end else if (ar_take) begin
            ARREADY_O <= 1'b0;
            RVALID_O  <= 1'b1;
            RDATA_O   <= rd_mux;
            RRESP_O   <= hit(ARADDR_I) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (RVALID_O & RREADY_I) begin
            RVALID_O  <= 1'b0;
            ARREADY_O <= 1'b1;
        end
    end

    // control registers, reset to power-up values [R10]
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            first_dir     <= `RST_DIR;         // [R10]
            analog_sel    <= `RST_ANALOG_SEL;  // [R3] [R10]
            comp_ctrl     <= `RST_COMP_CTRL;
            alt_ctrl      <= `RST_ALT_CTRL;
            second_dir    <= `RST_DIR;
            second_pullup <= `RST_PULLUP;
            chg_en        <= `RST_CHG_EN;
        end else if (wr_go && wr_lane0) begin
            // narrow registers live in byte lane zero
            case (wr_addr)
                `OFS_FIRST_DIR:     first_dir     <= wr_data[7:0];
                `OFS_ANALOG_SEL:    analog_sel    <= wr_data[7:0];
                `OFS_COMP_CTRL:     comp_ctrl     <= wr_data[7:0];
                `OFS_ALT_CTRL:      alt_ctrl[7:0] <= wr_data[7:0];
                `OFS_SECOND_DIR:    second_dir    <= wr_data[7:0];
                `OFS_SECOND_PULLUP: second_pullup <= wr_data[7:0];
                `OFS_SECOND_CHG_EN: chg_en        <= wr_data[7:4];
                default:            chg_en        <= chg_en;
            endcase
        end
        // the timer1 oscillator bit sits in lane one
        if (!RESET_I && wr_go && wr_strb[1] && wr_addr == `OFS_ALT_CTRL) begin
            alt_ctrl[`ALT_T1_OSC_EN] <= wr_data[`ALT_T1_OSC_EN];
        end
    end

    // data latches: no reset so other resets leave them unchanged [R10]
    // a write stores the lane-zero data, or the pins read when lane zero is not strobed [R5]
    always @(posedge CLK_SYS_I) begin
        if (!RESET_I && wr_go && wr_addr == `OFS_FIRST_DATA) begin
            first_latch <= wr_lane0 ? wr_data[7:0] : pa_read; // [R5]
        end
        if (!RESET_I && wr_go && wr_addr == `OFS_SECOND_DATA) begin
            second_latch <= wr_lane0 ? wr_data[7:0] : pb_read; // [R5]
        end
    end

    // change detect: any read or write of the second data register ends the mismatch, set beats clear [R16]
    wire pb_access = (wr_go && wr_addr == `OFS_SECOND_DATA) ||
                     (ar_take && ARADDR_I == `OFS_SECOND_DATA);
    wire flag_clr  = wr_go && wr_lane0 && wr_addr == `OFS_STATUS &&
                     wr_data[`STAT_CHANGE];
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            last_read   <= 4'h0;
            change_flag <= 1'b0;
        end else begin
            if (pb_access) begin
                last_read <= pb_sync[7:4];
            end
            if (mismatch) begin
                change_flag <= 1'b1;          // [R16]
            end else if (flag_clr) begin
                change_flag <= 1'b0;
            end
        end
    end

    // first port pin drive with alternate override
    reg [7:0] next_pa_out;      // next drive value
    reg [7:0] next_pa_oe;       // next drive enable
    always @* begin
        // direction alone sets drive, analog select ignored [R1] [R2] [R6] [R18]
        next_pa_oe  = ~first_dir;
        next_pa_out = first_latch & ~first_dir;
        // pin three never drives [R11]
        next_pa_oe[3]  = 1'b0;
        next_pa_out[3] = 1'b0;
        // comparator one output owns pin four [R12] [R19]
        if (c1_out_en) begin
            next_pa_oe[4]  = 1'b1;
            next_pa_out[4] = COMP1_OUT_I;
        end
        // comparator two output owns pin five [R13] [R19]
        if (c2_out_en) begin
            next_pa_oe[5]  = 1'b1;
            next_pa_out[5] = COMP2_OUT_I;
        end
        // oscillator takes pins six and seven away from the port [R14] [R19]
        if (osc_owns) begin
            next_pa_oe[7:6]  = 2'b00;
            next_pa_out[7:6] = 2'b00;
        end
    end

    // second port drive and pull-ups
    reg [7:0] next_pb_out;      // next drive value
    reg [7:0] next_pb_oe;       // next drive enable
    reg [7:0] next_pullup;      // next pull-up enables
    always @* begin
        next_pb_oe  = ~second_dir;
        next_pb_out = second_latch & ~second_dir;
        // pull-up only while the pin is an input [R16]
        next_pullup = second_pullup & second_dir;
    end

    // registered pin outputs; latches gated so reset shows zero
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            PA_OUT_O      <= 8'h00;
            PA_OE_O       <= 8'h00;
            PB_OUT_O      <= 8'h00;
            PB_OE_O       <= 8'h00;
            PB_PULLUP_O   <= 8'h00;
            TIMER0_CLK_O  <= 1'b0;
            SLAVE_SEL_O   <= 1'b0;
            DISP_PIN3_O   <= 1'b0;
            OSC_PINS_O    <= 1'b0;
            CHANGE_FLAG_O <= 1'b0;
        end else begin
            PA_OUT_O      <= next_pa_out;
            PA_OE_O       <= next_pa_oe;
            PB_OUT_O      <= next_pb_out;
            PB_OE_O       <= next_pb_oe;
            PB_PULLUP_O   <= next_pullup;
            // timer0 clock taken from the synced pin four [R12]
            TIMER0_CLK_O  <= alt_ctrl[`ALT_T0_CLK_EN] & pa_sync[4];
            // slave select input from pin five, idle high [R13]
            SLAVE_SEL_O   <= alt_ctrl[`ALT_SS_EN] ? pa_sync[5] : 1'b1;
            DISP_PIN3_O   <= disp_pin3;       // [R15]
            OSC_PINS_O    <= osc_owns;        // [R14]
            CHANGE_FLAG_O <= change_flag;
        end
    end

endmodule

// *** pkg/port_gpio_regs.vh ***
`ifndef PORT_GPIO_REGS_VH
`define PORT_GPIO_REGS_VH

// register byte offsets
`define OFS_FIRST_DATA      8'h00
`define OFS_FIRST_DIR       8'h04
`define OFS_ANALOG_SEL      8'h08
`define OFS_COMP_CTRL       8'h0c
`define OFS_ALT_CTRL        8'h10
`define OFS_SECOND_DATA     8'h14
`define OFS_SECOND_DIR      8'h18
`define OFS_SECOND_PULLUP   8'h1c
`define OFS_SECOND_CHG_EN   8'h20
`define OFS_STATUS          8'h24

// reset values
`define RST_DIR             8'hff
`define RST_ANALOG_SEL      8'hff
`define RST_COMP_CTRL       8'h00
`define RST_ALT_CTRL        9'h000
`define RST_PULLUP          8'hff
`define RST_CHG_EN          4'h0

// alternate control field positions
`define ALT_DISP_EN         0
`define ALT_SEG15_EN        1
`define ALT_OSC_LO          2
`define ALT_OSC_HI          3
`define ALT_C1_OUT_EN       4
`define ALT_C2_OUT_EN       5
`define ALT_T0_CLK_EN       6
`define ALT_SS_EN           7
`define ALT_T1_OSC_EN       8

// oscillator mode codes
`define OSC_CRYSTAL         2'h1
`define OSC_HIGH_SPEED      2'h2
`define OSC_LOW_POWER       2'h3

// status bit: change flag
`define STAT_CHANGE         0

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// *** verilog/pin_sync.v ***
`timescale 1ns/1ns
// two-stage synchroniser, one per pin
module pin_sync #(
    parameter WIDTH = 16
) (
    input  wire             clk_i,   // system clock
    input  wire [WIDTH-1:0] async_i, // raw pin levels
    output wire [WIDTH-1:0] sync_o   // levels after two flops
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta;   // first stage, read only by stage two
            reg stable; // second stage
            // no reset: pure sampling chain
            always @(posedge clk_i) begin
                meta   <= async_i[g];
                stable <= meta;
            end
            assign sync_o[g] = stable;
        end
    endgenerate

endmodule

// *** verif/pin_board.sv ***
`timescale 1ns/1ns
// board side of one 8-pin port: resolves each wire from all drivers
module pin_board (
    input  wire logic       clk_i,    // system clock
    input  wire logic [7:0] out_i,    // device drive value
    input  wire logic [7:0] oe_i,     // device drive enable
    input  wire logic [7:0] pull_i,   // weak pull-up active
    input  wire logic [7:0] ext_i,    // board drive value
    input  wire logic [7:0] ext_en_i, // board drive enable
    output wire logic [7:0] pin_o     // level seen on the wires
);
    // undriven, unpulled wires wander so a stale value never passes
    logic [7:0] float_q = 8'h55; // floating level
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    // device wins where it drives, else board, else pull or float
    assign pin_o = (oe_i & out_i)
                 | (~oe_i & ext_en_i & ext_i)
                 | (~oe_i & ~ext_en_i & (pull_i | float_q));
endmodule

// *** verif/port_gpio_sva.sv ***
`timescale 1ns/1ns
// pin and bus relations of the port block
module port_gpio_sva (
    input wire logic        CLK_SYS_I,    // clock
    input wire logic        RESET_I,      // reset
    input wire logic        AWVALID_I,    // write address valid
    input wire logic        AWREADY_O,    // write address ready
    input wire logic        WVALID_I,     // write data valid
    input wire logic        WREADY_O,     // write data ready
    input wire logic        BVALID_O,     // write response valid
    input wire logic        ARVALID_I,    // read address valid
    input wire logic        ARREADY_O,    // read address ready
    input wire logic        RVALID_O,     // read data valid
    input wire logic        RREADY_I,     // read data ready
    input wire logic [31:0] RDATA_O,      // read data
    input wire logic [7:0]  PA_IN_I,      // first port levels
    input wire logic [7:0]  PA_OE_O,      // first port drive enable
    input wire logic [7:0]  PB_OE_O,      // second port drive enable
    input wire logic        TIMER0_CLK_O, // pin four clock
    input wire logic        SLAVE_SEL_O,  // pin five select
    input wire logic        OSC_PINS_O    // oscillator owns 7:6
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    rst_release_a: assert property ($fell(RESET_I) |-> (PA_OE_O == 8'h00 && PB_OE_O == 8'h00) [*3])
        else $error("pins driven right after reset");
    pin3_input_a: assert property (!PA_OE_O[3])
        else $error("pin three driven");
    osc_owns_a: assert property (OSC_PINS_O |-> PA_OE_O[7:6] == 2'b00)
        else $error("oscillator pins driven by port");
    t0_clock_a: assert property ($rose(TIMER0_CLK_O) |-> $past(PA_IN_I[4], 2) || $past(PA_IN_I[4], 3))
        else $error("timer clock rose without pin four high");
    slave_sel_a: assert property ($fell(SLAVE_SEL_O) |-> !$past(PA_IN_I[5], 2) || !$past(PA_IN_I[5], 3))
        else $error("select fell without pin five low");
    wr_answer_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |=> ##1 BVALID_O)
        else $error("write response late");
    rd_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
        else $error("read response late");
    rd_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
        else $error("read data dropped before taken");
    wr_refuse_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("write taken while response pending");
endmodule

bind port_gpio port_gpio_sva i_sva (.*);

// *** verif/bidirectional_port_a_gpio_tb.sv ***
`timescale 1ns/1ns
`include "port_gpio_regs.vh"
module bidirectional_port_a_gpio_tb;
    logic        clk, reset, awvalid, wvalid, bready, arvalid, rready, comp1, comp2;
    logic [7:0]  awaddr, araddr, pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe, pb_pull, ext, ext_en;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, t0_clk, ss_sel, disp3, osc, chg;
    int          err_count, comparisons, cycles;
    port_gpio i_dut (.CLK_SYS_I(clk), .RESET_I(reset), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
        .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .PA_IN_I(pa_in), .PA_OUT_O(pa_out), .PA_OE_O(pa_oe), .PB_IN_I(pb_in), .PB_OUT_O(pb_out),
        .PB_OE_O(pb_oe), .PB_PULLUP_O(pb_pull), .COMP1_OUT_I(comp1), .COMP2_OUT_I(comp2),
        .TIMER0_CLK_O(t0_clk), .SLAVE_SEL_O(ss_sel), .DISP_PIN3_O(disp3), .OSC_PINS_O(osc),
        .CHANGE_FLAG_O(chg));
    // first port has no pull-ups; second port uses the block's own
    pin_board i_pa (.clk_i(clk), .out_i(pa_out), .oe_i(pa_oe), .pull_i(8'h00), .ext_i(ext),
        .ext_en_i(ext_en), .pin_o(pa_in));
    pin_board i_pb (.clk_i(clk), .out_i(pb_out), .oe_i(pb_oe), .pull_i(pb_pull), .ext_i(8'h00),
        .ext_en_i(8'h00), .pin_o(pb_in));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, far above the whole sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask
    // both write channels offered together, response checked
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // each channel released at its own ready, either order
        fork
            @(posedge clk iff awready) awvalid <= 1'b0;
            @(posedge clk iff wready) wvalid <= 1'b0;
        join
        bready <= 1'b1;
        @(posedge clk iff bvalid);
        bready <= 1'b0;
        chk("bresp", r, bresp);
    endtask
    // late rready so the held-answer case is exercised
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge clk iff arready);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        @(posedge clk iff rvalid);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", r, rresp);
    endtask
    task automatic rst;
        reset <= 1'b1;
        pause(4);
        reset <= 1'b0;
    endtask
    task automatic t_reset;
        rd(`OFS_FIRST_DIR, 32'hff, `RESP_OKAY);
        rd(`OFS_ANALOG_SEL, 32'hff, `RESP_OKAY);
        rd(`OFS_FIRST_DATA, 32'hd0, `RESP_OKAY);
        chk("pa_oe", 8'h00, pa_oe);
        chk("pb_pull", 8'hff, pb_pull);
        $display("test reset done");
    endtask
    task automatic t_digital;
        wr(`OFS_COMP_CTRL, 32'h07, 4'h1, `RESP_OKAY);
        wr(`OFS_ANALOG_SEL, 32'h00, 4'h1, `RESP_OKAY);
        ext_en <= 8'hf8;
        ext <= 8'hc8;
        wr(`OFS_FIRST_DATA, 32'ha5, 4'h1, `RESP_OKAY);
        wr(`OFS_FIRST_DIR, 32'hf0, 4'h1, `RESP_OKAY);
        pause(3);
        chk("pa_oe", 8'h07, pa_oe);
        chk("pa_out", 8'h05, pa_out & pa_oe);
        rd(`OFS_FIRST_DATA, 32'hcd, `RESP_OKAY);
        wr(`OFS_ANALOG_SEL, 32'h01, 4'h1, `RESP_OKAY);
        pause(3);
        chk("pa_oe", 8'h07, pa_oe);
        rd(`OFS_FIRST_DATA, 32'hcc, `RESP_OKAY);
        $display("test digital done");
    endtask
    task automatic t_rmw;
        wr(`OFS_ANALOG_SEL, 32'h00, 4'h1, `RESP_OKAY);
        ext <= 8'h30;
        pause(3);
        // no byte lane: latch takes the pins, not the bus data
        wr(`OFS_FIRST_DATA, 32'hff, 4'h0, `RESP_OKAY);
        ext_en <= 8'h00;
        wr(`OFS_FIRST_DIR, 32'h00, 4'h1, `RESP_OKAY);
        pause(2);
        chk("pa_oe", 8'hf7, pa_oe);
        chk("pa_out", 8'h35, pa_out & pa_oe);
        $display("test rmw done");
    endtask
    task automatic t_osc;
        for (int m = 0; m < 4; m++) begin
            wr(`OFS_ALT_CTRL, m << 2, 4'h1, `RESP_OKAY);
            pause(2);
            rd(`OFS_FIRST_DIR, (m != 0) ? 32'hc0 : 32'h00, `RESP_OKAY);
            chk("osc", m != 0, osc);
            chk("pa_oe_hi", (m != 0) ? 2'b00 : 2'b11, pa_oe[7:6]);
        end
        // timer1 oscillator alone: pins taken, readback not forced
        wr(`OFS_ALT_CTRL, 32'h100, 4'h3, `RESP_OKAY);
        pause(2);
        rd(`OFS_FIRST_DIR, 32'h00, `RESP_OKAY);
        chk("osc", 1'b1, osc);
        chk("pa_oe_hi", 2'b00, pa_oe[7:6]);
        $display("test osc done");
    endtask
    task automatic t_alt;
        wr(`OFS_FIRST_DIR, 32'hff, 4'h1, `RESP_OKAY);
        wr(`OFS_ALT_CTRL, 32'h30, 4'h3, `RESP_OKAY);
        for (int k = 1; k < 3; k++) begin
            comp1 <= k[0];
            comp2 <= k[1];
            pause(3);
            chk("pa_oe_mid", 2'b11, pa_oe[5:4]);
            chk("pa_out_mid", k, pa_out[5:4]);
        end
        wr(`OFS_ALT_CTRL, 32'hc0, 4'h1, `RESP_OKAY);
        ext_en <= 8'hff;
        for (int k = 1; k < 3; k++) begin
            ext <= k << 4;
            pause(5);
            chk("t0_clk", k[0], t0_clk);
            chk("ss_sel", k[1], ss_sel);
        end
        for (int k = 0; k < 4; k++) begin
            wr(`OFS_ALT_CTRL, k, 4'h1, `RESP_OKAY);
            pause(2);
            chk("disp3", k == 3, disp3);
        end
        $display("test alternate done");
    endtask
    task automatic t_unmapped;
        wr(8'h3c, 32'h05, 4'h1, `RESP_SLVERR);
        rd(8'h3c, 32'h00, `RESP_SLVERR);
        $display("test unmapped done");
    endtask
    // second port drive, pull-ups and change flag
    task automatic t_second;
        wr(`OFS_SECOND_DATA, 32'ha5, 4'h1, `RESP_OKAY);
        wr(`OFS_SECOND_DIR, 32'hf0, 4'h1, `RESP_OKAY);
        pause(3);
        chk("pb_oe", 8'h0f, pb_oe);
        chk("pb_out", 8'h05, pb_out);
        chk("pb_pull", 8'hf0, pb_pull);
        rd(`OFS_SECOND_DATA, 32'hf5, `RESP_OKAY);
        wr(`OFS_SECOND_CHG_EN, 32'hf0, 4'h1, `RESP_OKAY);
        wr(`OFS_SECOND_DIR, 32'h00, 4'h1, `RESP_OKAY);
        pause(6);
        chk("chg", 1'b1, chg);
        rd(`OFS_STATUS, 32'h01, `RESP_OKAY);
        rd(`OFS_SECOND_DATA, 32'ha5, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h01, 4'h1, `RESP_OKAY);
        pause(2);
        chk("chg", 1'b0, chg);
        $display("test second port done");
    endtask
    // second reset: directions back to input, latch keeps its value
    task automatic t_reset2;
        ext_en <= 8'h00;
        rst();
        chk("pa_oe", 8'h00, pa_oe);
        rd(`OFS_FIRST_DIR, 32'hff, `RESP_OKAY);
        wr(`OFS_FIRST_DIR, 32'h00, 4'h1, `RESP_OKAY);
        pause(2);
        chk("pa_out", 8'h35, pa_out & pa_oe);
        $display("test second reset done");
    endtask
    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready, comp1, comp2} = 8'h80;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        ext = 8'hff;
        ext_en = 8'hff;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        @(posedge clk);
        rst();
        t_reset();
        t_digital();
        t_rmw();
        t_osc();
        t_alt();
        t_unmapped();
        t_second();
        t_reset2();
        results();
    end
endmodule
